// >>> hdl/sfi_pkg.sv
// Constants, opcodes and state codes for the serial flash interface
`default_nettype none
package sfi_pkg;
    localparam int CLK_MHZ       = 50;
    localparam int PAGE_PROG_US  = 1200;
    localparam int ERASE_4K_US   = 50000;
    localparam int ERASE_32K_US  = 250000;
    localparam int ERASE_64K_US  = 400000;
    localparam int CHIP_ERASE_US = 4000000;
    localparam int BYTE_PROG_US  = 20;

    localparam int ADDR_W    = 19;
    localparam int MEM_BYTES = 524288;
    localparam int PAGE_BYTES = 256;
    localparam int SECT_N    = 11;
    localparam int BLK64_LSB = 16;
    localparam int PAGE_LSB  = 8;

    localparam logic [ADDR_W-1:0] MASK_4K     = 19'h00fff;
    localparam logic [ADDR_W-1:0] MASK_32K    = 19'h07fff;
    localparam logic [ADDR_W-1:0] MASK_64K    = 19'h0ffff;
    localparam logic [ADDR_W-1:0] SECT32_BASE = 19'h70000;
    localparam logic [ADDR_W-1:0] SECT8A_BASE = 19'h78000;
    localparam logic [ADDR_W-1:0] SECT8B_BASE = 19'h7a000;
    localparam logic [ADDR_W-1:0] SECT16_BASE = 19'h7c000;
    localparam logic [3:0]        SECT32_IDX  = 4'h7;
    localparam logic [3:0]        SECT8A_IDX  = 4'h8;
    localparam logic [3:0]        SECT8B_IDX  = 4'h9;
    localparam logic [3:0]        SECT16_IDX  = 4'ha;
    localparam logic [19:0]       LEN_ONE     = 20'h00001;
    localparam logic [19:0]       LEN_4K      = 20'h01000;
    localparam logic [19:0]       LEN_32K     = 20'h08000;
    localparam logic [19:0]       LEN_64K     = 20'h10000;
    localparam logic [19:0]       LEN_CHIP    = 20'h80000;
    localparam logic [8:0]        PAGE_FULL   = 9'h100;
    localparam logic [7:0]        ERASED      = 8'hff;

    localparam logic [7:0] OP_READ   = 8'h03;
    localparam logic [7:0] OP_PROG   = 8'h02;
    localparam logic [7:0] OP_SEQ    = 8'had;
    localparam logic [7:0] OP_E4K    = 8'h20;
    localparam logic [7:0] OP_E32K   = 8'h52;
    localparam logic [7:0] OP_E64K   = 8'hd8;
    localparam logic [7:0] OP_CHIP   = 8'hc7;
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_WRSR   = 8'h01;
    localparam logic [7:0] OP_PROT   = 8'h36;
    localparam logic [7:0] OP_UNPROT = 8'h39;
    localparam logic [7:0] OP_RDID   = 8'h9f;

    localparam int ST_BUSY = 0;
    localparam int ST_WEL  = 1;
    localparam int ST_PANY = 2;
    localparam int ST_PALL = 3;
    localparam int ST_WP   = 4;
    localparam int ST_FAIL = 5;
    localparam int ST_SEQ  = 6;
    localparam int ST_ZERO = 7;
    localparam int GLOB_LSB = 2;
    localparam int GLOB_MSB = 5;
    localparam logic [3:0] GLOB_ALL  = 4'hf;
    localparam logic [3:0] GLOB_NONE = 4'h0;

    // Arbitrary identification values
    localparam logic [7:0] MFR_ID    = 8'h5a;
    localparam logic [7:0] DEV_ID_HI = 8'h3c;
    localparam logic [7:0] DEV_ID_LO = 8'h01;

    localparam int PIN_CS   = 4;
    localparam int PIN_SCK  = 3;
    localparam int PIN_SI   = 2;
    localparam int PIN_WP   = 1;
    localparam int PIN_HOLD = 0;
    localparam logic [4:0] PIN_RST = 5'h1f;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_CMD  = 5'b00010,
        RX_ADDR = 5'b00100,
        RX_DATA = 5'b01000,
        RX_OUT  = 5'b10000
    } sfi_rx_t;

    typedef enum logic [2:0] {
        EX_IDLE = 3'b001,
        EX_WALK = 3'b010,
        EX_WAIT = 3'b100
    } sfi_ex_t;
endpackage
`default_nettype wire

// >>> hdl/sfi_flash_core.sv
// Serial flash device: pin front end, command framing, array, protection
//
// How it works
// - Accepts host clock modes 0 and 3; edges found by sampling sck.
// - Chip select high deselects and gives standby, not deep power-down.
// - While deselected the serial output is not driven.
// - While deselected serial input bits are ignored.
// - Chip select rising ends the current operation.
// - Standby waits until a running program or erase finishes.
// - Serial input sampled on rising sck edges during command, address and data bytes.
// - Serial output changes only on falling sck edges.
// - One program writes one to 256 bytes within a page.
// - Sequential program mode writes next byte without resending address.
// - Erase of aligned 4K, 32K, 64K blocks and whole array.
// - Eleven protection sectors: 16K top, two 8K, one 32K, seven 64K.
// - Global protect and unprotect set or clear all sectors at once.
// - Write-protect pin low blocks unprotecting any sector.
// - Program and erase checked; failure flag readable afterwards.
// - Identification read returns maker and device codes.
// - Busy times: 1.2 ms page, 50/250/400 ms block erases.
// - Hold low freezes sck and si and releases the output.
// - Write-protect and hold inputs default to deasserted.
`default_nettype none
module sfi_flash_core #(
    parameter int unsigned PageProgCycles   = sfi_pkg::PAGE_PROG_US * sfi_pkg::CLK_MHZ,
    parameter int unsigned Erase4kCycles    = sfi_pkg::ERASE_4K_US * sfi_pkg::CLK_MHZ,
    parameter int unsigned Erase32kCycles   = sfi_pkg::ERASE_32K_US * sfi_pkg::CLK_MHZ,
    parameter int unsigned Erase64kCycles   = sfi_pkg::ERASE_64K_US * sfi_pkg::CLK_MHZ,
    parameter int unsigned ChipEraseCycles  = sfi_pkg::CHIP_ERASE_US * sfi_pkg::CLK_MHZ,
    parameter int unsigned ByteProgCycles   = sfi_pkg::BYTE_PROG_US * sfi_pkg::CLK_MHZ
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic csN,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic wpN,
    input  wire logic holdN,
    output logic      so,
    output logic      soOe,
    output logic      standby,
    output logic      busy
);
    import sfi_pkg::*;

    logic [4:0]          pinMeta;
    logic [4:0]          pinSync;
    logic                sckPrev;
    logic                csPrev;
    sfi_rx_t             rxState;
    sfi_ex_t             exState;
    logic [2:0]          bitCnt;
    logic [7:0]          shiftIn;
    logic [7:0]          cmd;
    logic [ADDR_W-1:0]   addr;
    logic [1:0]          addrCnt;
    logic                frameOk;
    logic [7:0]          pageOff;
    logic [8:0]          pageCnt;
    logic [7:0]          stsData;
    logic [7:0]          outShift;
    logic [2:0]          outBit;
    logic [ADDR_W-1:0]   rdOff;
    logic [1:0]          idIdx;
    logic [ADDR_W-1:0]   walkAddr;
    logic [19:0]         walkLeft;
    logic                walkFill;
    logic [31:0]         timer;
    logic                fail;
    logic                wel;
    logic                seqMode;
    logic [ADDR_W-1:0]   seqNext;
    logic [SECT_N-1:0]   protBits;
    logic [7:0]          mem [MEM_BYTES];
    logic [7:0]          pageBuf [PAGE_BYTES];

    function automatic logic [3:0] sectorOf(input logic [ADDR_W-1:0] a);
        if (a >= SECT16_BASE) sectorOf = SECT16_IDX;
        else if (a >= SECT8B_BASE) sectorOf = SECT8B_IDX;
        else if (a >= SECT8A_BASE) sectorOf = SECT8A_IDX;
        else if (a >= SECT32_BASE) sectorOf = SECT32_IDX;
        else sectorOf = {1'b0, a[ADDR_W-1:BLK64_LSB]};
    endfunction

    // Pin synchronisers; pulled-up pins reset to their idle level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pinMeta <= PIN_RST;
            pinSync <= PIN_RST;
        end else if (ce) begin
            pinMeta <= {csN, sck, si, wpN, holdN};
            pinSync <= pinMeta;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sckPrev <= PIN_RST[PIN_SCK];
            csPrev  <= PIN_RST[PIN_CS];
        end else if (ce) begin
            sckPrev <= pinSync[PIN_SCK];
            csPrev  <= pinSync[PIN_CS];
        end
    end

    wire csS     = pinSync[PIN_CS];
    wire sckS    = pinSync[PIN_SCK];
    wire siS     = pinSync[PIN_SI];
    wire wpS     = pinSync[PIN_WP];
    wire holdS   = pinSync[PIN_HOLD];
    // Hold masks sck edges; an edge seen across the hold is dropped
    wire active  = !csS && holdS;
    // Only edges matter, so idle level (mode 0 or 3) needs no setting
    wire sckRise = ce && active && sckS && !sckPrev;
    wire sckFall = ce && active && !sckS && sckPrev;
    wire csRise  = ce && csS && !csPrev;
    wire csFall  = ce && !csS && csPrev;
    wire rxIn    = rxState == RX_CMD || rxState == RX_ADDR || rxState == RX_DATA;
    wire byteDone = sckRise && rxIn && bitCnt == 3'h7;
    wire [7:0] newByte = {shiftIn[6:0], siS};
    wire [ADDR_W-1:0] addrNext = {addr[ADDR_W-9:0], newByte};

    // Command classes decoded from the byte just completed
    wire cmdAddr = newByte == OP_READ || newByte == OP_PROG || newByte == OP_E4K || newByte == OP_E32K
                || newByte == OP_E64K || newByte == OP_PROT || newByte == OP_UNPROT
                || (newByte == OP_SEQ && !seqMode);
    wire cmdOut  = newByte == OP_RDSR || newByte == OP_RDID;
    wire cmdData = newByte == OP_WRSR || (newByte == OP_SEQ && seqMode);
    wire cmdBare = newByte == OP_WREN || newByte == OP_WRDI || newByte == OP_CHIP;
    // Only status polling is served during a self-timed cycle
    wire cmdOk   = !busy || newByte == OP_RDSR;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            shiftIn <= 8'h00;
            bitCnt  <= 3'h0;
        end else if (csFall) begin
            bitCnt  <= 3'h0;
        end else if (sckRise && rxIn) begin
            shiftIn <= newByte;
            bitCnt  <= bitCnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxState <= RX_IDLE;
            cmd     <= 8'h00;
            addr    <= '0;
            addrCnt <= 2'h0;
            frameOk <= 1'b0;
            pageOff <= 8'h00;
            pageCnt <= 9'h000;
            stsData <= 8'h00;
        end else if (csRise) begin
            rxState <= RX_IDLE;
        end else if (csFall) begin
            rxState <= RX_CMD;
            addrCnt <= 2'h0;
            frameOk <= 1'b0;
            pageCnt <= 9'h000;
        end else if (byteDone) begin
            case (rxState)
                RX_CMD: begin
                    cmd <= newByte;
                    if (!cmdOk) rxState <= RX_IDLE;
                    else if (cmdAddr) rxState <= RX_ADDR;
                    else if (cmdOut) rxState <= RX_OUT;
                    else if (cmdData) begin
                        rxState <= RX_DATA;
                        pageOff <= seqNext[PAGE_LSB-1:0];
                    end else begin
                        frameOk <= cmdBare;
                        rxState <= RX_IDLE;
                    end
                end
                RX_ADDR: begin
                    addr    <= addrNext;
                    addrCnt <= addrCnt + 2'h1;
                    if (addrCnt == 2'h2) begin
                        if (cmd == OP_READ) rxState <= RX_OUT;
                        else if (cmd == OP_PROG || cmd == OP_SEQ) begin
                            rxState <= RX_DATA;
                            pageOff <= addrNext[PAGE_LSB-1:0];
                        end else begin
                            frameOk <= 1'b1;
                            rxState <= RX_IDLE;
                        end
                    end
                end
                RX_DATA: begin
                    frameOk <= 1'b1;
                    if (cmd == OP_PROG) begin
                        // Offset wraps inside the page; count caps at one page
                        pageOff <= pageOff + 8'h01;
                        if (pageCnt != PAGE_FULL) pageCnt <= pageCnt + 9'h001;
                    end else begin
                        stsData <= newByte;
                        rxState <= RX_IDLE;
                    end
                end
                default: rxState <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce && byteDone && rxState == RX_DATA && cmd != OP_WRSR) pageBuf[pageOff] <= newByte;
    end

    // Read data source for the output shifter
    wire [7:0] statusByte;
    assign statusByte[ST_BUSY] = busy;
    assign statusByte[ST_WEL]  = wel;
    assign statusByte[ST_PANY] = |protBits;
    assign statusByte[ST_PALL] = &protBits;
    assign statusByte[ST_WP]   = wpS;
    assign statusByte[ST_FAIL] = fail;
    assign statusByte[ST_SEQ]  = seqMode;
    assign statusByte[ST_ZERO] = 1'b0;
    wire [7:0] idByte = idIdx == 2'h0 ? MFR_ID : idIdx == 2'h1 ? DEV_ID_HI : idIdx == 2'h2 ? DEV_ID_LO : 8'h00;
    wire [7:0] outByte = cmd == OP_READ ? mem[addr + rdOff] : cmd == OP_RDSR ? statusByte : idByte;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            so       <= 1'b0;
            outShift <= 8'h00;
            outBit   <= 3'h0;
            rdOff    <= '0;
            idIdx    <= 2'h0;
        end else if (csFall) begin
            so     <= 1'b0;
            outBit <= 3'h0;
            rdOff  <= '0;
            idIdx  <= 2'h0;
        end else if (sckFall && rxState == RX_OUT) begin
            outBit <= outBit + 3'h1;
            if (outBit == 3'h0) begin
                so       <= outByte[7];
                outShift <= {outByte[6:0], 1'b0};
                rdOff    <= rdOff + 19'h00001;
                if (idIdx != 2'h3) idIdx <= idIdx + 2'h1;
            end else begin
                so       <= outShift[7];
                outShift <= {outShift[6:0], 1'b0};
            end
        end
    end

    assign soOe = active && rxState == RX_OUT;

    // Launch decode at the end of a complete frame
    wire launch   = csRise && frameOk && !busy;
    wire opWren   = launch && cmd == OP_WREN;
    wire opWrdi   = launch && cmd == OP_WRDI;
    wire opProg   = launch && wel && cmd == OP_PROG;
    wire opSeq    = launch && wel && cmd == OP_SEQ;
    wire opE4     = launch && wel && cmd == OP_E4K;
    wire opE32    = launch && wel && cmd == OP_E32K;
    wire opE64    = launch && wel && cmd == OP_E64K;
    wire opChip   = launch && wel && cmd == OP_CHIP;
    wire opProt   = launch && wel && cmd == OP_PROT;
    wire opUnprot = launch && wel && cmd == OP_UNPROT && wpS;
    wire opWrsr   = launch && wel && cmd == OP_WRSR;
    wire [3:0] globCode = stsData[GLOB_MSB:GLOB_LSB];
    wire globSet  = opWrsr && globCode == GLOB_ALL;
    wire globClr  = opWrsr && globCode == GLOB_NONE && wpS;
    wire isErase  = opE4 || opE32 || opE64 || opChip;
    wire doWalk   = opProg || opSeq || isErase;
    wire [ADDR_W-1:0] eraseMask = opE4 ? MASK_4K : opE32 ? MASK_32K : MASK_64K;
    wire [ADDR_W-1:0] walkBase = opSeq && seqMode ? seqNext : (opProg || opSeq) ? addr
                               : opChip ? '0 : addr & ~eraseMask;
    wire [19:0] walkLen = opSeq ? LEN_ONE : opProg ? {11'h000, pageCnt} : opE4 ? LEN_4K
                        : opE32 ? LEN_32K : opE64 ? LEN_64K : LEN_CHIP;
    wire [31:0] walkCycles = opSeq ? 32'(ByteProgCycles) : opProg ? 32'(PageProgCycles)
                           : opE4 ? 32'(Erase4kCycles) : opE32 ? 32'(Erase32kCycles)
                           : opE64 ? 32'(Erase64kCycles) : 32'(ChipEraseCycles);
    wire walkProt = protBits[sectorOf(walkAddr)];
    wire walkWr   = exState == EX_WALK && !walkProt;
    // Flash cells only clear bits, so program merges with the old byte
    wire [7:0] walkData = walkFill ? ERASED : mem[walkAddr] & pageBuf[walkAddr[PAGE_LSB-1:0]];
    wire [ADDR_W-1:0] walkStep = walkFill ? walkAddr + 19'h00001
                               : {walkAddr[ADDR_W-1:PAGE_LSB], walkAddr[PAGE_LSB-1:0] + 8'h01};

    assign busy = exState != EX_IDLE;

    always_ff @(posedge sys_clk) begin
        if (ce && walkWr) mem[walkAddr] <= walkData;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            exState  <= EX_IDLE;
            walkAddr <= '0;
            walkLeft <= 20'h00000;
            walkFill <= 1'b0;
            timer    <= 32'h0;
        end else if (ce) begin
            if (timer != 32'h0) timer <= timer - 32'h1;
            case (exState)
                EX_IDLE: if (doWalk) begin
                    exState  <= EX_WALK;
                    walkAddr <= walkBase;
                    walkLeft <= walkLen;
                    walkFill <= isErase;
                    timer    <= walkCycles;
                end
                EX_WALK: begin
                    walkAddr <= walkStep;
                    walkLeft <= walkLeft - 20'h00001;
                    if (walkLeft == LEN_ONE) exState <= EX_WAIT;
                end
                EX_WAIT: if (timer == 32'h0) exState <= EX_IDLE;
                default: exState <= EX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wel      <= 1'b0;
            seqMode  <= 1'b0;
            seqNext  <= '0;
            fail     <= 1'b0;
            protBits <= '0;
        end else if (ce) begin
            if (opWren) wel <= 1'b1;
            if (opWrdi) begin
                wel     <= 1'b0;
                seqMode <= 1'b0;
            end
            if (opProt || opUnprot || opWrsr) wel <= 1'b0;
            if (exState == EX_WAIT && timer == 32'h0) wel <= seqMode;
            if (opSeq) begin
                seqMode <= 1'b1;
                seqNext <= walkBase + 19'h00001;
            end
            if (doWalk) fail <= 1'b0;
            else if (exState == EX_WALK && walkProt) fail <= 1'b1;
            if (opProt) protBits[sectorOf(addr)] <= 1'b1;
            if (opUnprot) protBits[sectorOf(addr)] <= 1'b0;
            if (globSet) protBits <= '1;
            if (globClr) protBits <= '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) standby <= 1'b0;
        // A program or erase launch at this edge raises busy next cycle; keep standby low meanwhile
        else if (ce) standby <= csS && !busy && !doWalk;
    end

    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (srst);

    so_desel_hiz_a: assert property (csS |-> !soOe) else $error("output driven while deselected");
    hold_out_hiz_a: assert property (!holdS |-> !soOe) else $error("output driven during hold");
    desel_si_ignore_a: assert property (csS |=> $stable(shiftIn) && $stable(bitCnt))
        else $error("input shifted while deselected");
    cs_rise_end_a: assert property (csRise |=> rxState == RX_IDLE) else $error("frame not ended");
    standby_enter_a: assert property (csRise && !busy && !doWalk |=> standby) else $error("no standby");
    standby_defer_a: assert property ($fell(busy) && csS |-> !standby ##1 standby)
        else $error("standby not deferred to end of busy");
    rise_sample_a: assert property (sckRise && rxIn |=> shiftIn[0] == $past(siS))
        else $error("input not sampled on rising edge");
    fall_change_a: assert property (soOe && $past(soOe) && so != $past(so) |-> $past(sckFall))
        else $error("output changed off falling edge");
    page_cap_a: assert property (pageCnt <= PAGE_FULL) else $error("page count over one page");
    wp_lock_a: assert property (!wpS |=> (protBits & $past(protBits)) == $past(protBits))
        else $error("sector unprotected under write protect");
    prot_fail_a: assert property (exState == EX_WALK && walkProt && !doWalk |=> fail)
        else $error("protected write not reported");
    global_set_a: assert property (globSet |=> &protBits) else $error("global protect missed");

    read_frame_c: cover property (rxState == RX_OUT && cmd == OP_READ && csRise);
    page_prog_c: cover property (opProg ##1 busy [*3] ##1 exState == EX_WAIT);
    erase_done_c: cover property (exState == EX_WAIT && walkFill ##1 !busy);
    hold_read_c: cover property (rxState == RX_OUT && !holdS);
endmodule // sfi_flash_core
`default_nettype wire

// >>> dv/sfi_host_model.sv
// Host SPI master model, mode 0, paced by the system clock
`default_nettype none
module sfi_host_model (
    input  wire logic       sys_clk,
    input  wire logic       so,
    input  wire logic       soOe,
    output logic            csN,
    output logic            sck,
    output logic            si,
    output logic            holdN,
    output logic [7:0]      rxByte,
    output logic            rxStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        holdN = 1'b1;
        rxByte = 8'h00;
        rxStrobe = 1'b0;
    end
    // Four clocks a phase, well above what the pin sampler needs
    task automatic bitx(input logic d, output logic q);
        si <= d;
        repeat (4) @(posedge sys_clk);
        sck <= 1'b1;
        repeat (4) @(posedge sys_clk);
        q = soOe ? so : 1'bx;
        sck <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] b);
        rxByte <= b;
        rxStrobe <= 1'b1;
        @(posedge sys_clk);
        rxStrobe <= 1'b0;
    endtask
    // Clocks a byte while chip select stays high
    task automatic noise(input logic [7:0] b);
        logic q;
        for (int i = 0; i < 8; i++) bitx(b[7-i], q);
    endtask
    task automatic frame(input logic [63:0] tx, input int nTx, input int nRx, input int holdAt);
        logic [7:0] b;
        @(posedge sys_clk);
        csN <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < nTx * 8; i++) bitx(tx[63-i], b[0]);
        for (int k = 0; k < nRx; k++) begin
            if (k == holdAt) begin
                holdN <= 1'b0;
                repeat (6) @(posedge sys_clk);
                sck <= 1'b1;
                repeat (4) @(posedge sys_clk);
                sck <= 1'b0;
                pulse({7'h00, soOe});
                repeat (4) @(posedge sys_clk);
                holdN <= 1'b1;
                repeat (4) @(posedge sys_clk);
            end
            // Unused input bits toggle so a stale level cannot pass
            for (int i = 7; i >= 0; i--) bitx(~si, b[i]);
            pulse(b);
        end
        repeat (4) @(posedge sys_clk);
        csN <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // sfi_host_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the serial flash device
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfi_pkg::*;
    logic            sys_clk = 1'b0;
    logic            srst = 1'b1;
    logic            wpN = 1'b1;
    wire logic       csN, sck, si, holdN, so, soOe, standby, busy, rxStrobe;
    wire logic [7:0] rxByte;
    int              n_errors = 0;
    int              num_checks = 0;
    integer          seed = 32'hc487caaf;
    logic [15:0]     expQ[$];
    logic [7:0]      r0, r1;
    always #10 sys_clk = ~sys_clk;
    // Short busy counts keep the run near fifteen thousand clocks
    sfi_flash_core #(.PageProgCycles(300), .Erase4kCycles(5000), .ByteProgCycles(50)) sfi_flash_core_inst (
        .sys_clk(sys_clk), .srst(srst), .ce(1'b1), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
        .holdN(holdN), .so(so), .soOe(soOe), .standby(standby), .busy(busy));
    sfi_host_model sfi_host_model_inst (
        .sys_clk(sys_clk), .so(so), .soOe(soOe), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
        .rxByte(rxByte), .rxStrobe(rxStrobe));
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
        num_checks++;
        if ((g & m) !== (e & m)) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic flag(input string name, input logic g, input logic e);
        check(name, {7'h00, e}, {7'h00, g}, 8'h01);
    endtask
    task automatic note(input logic [7:0] e, input logic [7:0] m);
        expQ.push_back({m, e});
    endtask
    task automatic go(input logic [63:0] tx, input int nTx, input int nRx, input int holdAt = -1);
        sfi_host_model_inst.frame(tx, nTx, nRx, holdAt);
    endtask
    task automatic waitIdle();
        for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        flag("busy", busy, 1'b0);
        flag("standby", standby, 1'b1);
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Oldest noted byte against each byte the host shifts in
    always @(posedge sys_clk) begin
        if (rxStrobe === 1'b1) begin
            check("so byte", expQ[0][7:0], rxByte, expQ[0][15:8]);
            void'(expQ.pop_front());
        end
    end
    initial begin
        #1500000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        note(MFR_ID, 8'hff);
        note(DEV_ID_HI, 8'hff);
        note(DEV_ID_LO, 8'hff);
        go({OP_RDID, 56'h0}, 1, 3);
        $display("test id done");
        sfi_host_model_inst.noise(OP_WREN);
        flag("standby", standby, 1'b1);
        flag("soOe", soOe, 1'b0);
        note(8'h10, 8'hff);
        go({OP_RDSR, 56'h0}, 1, 1);
        $display("test deselect done");
        go({OP_WREN, 56'h0}, 1, 0);
        go({OP_E4K, 24'h012000, 32'h0}, 4, 0);
        repeat (8) @(posedge sys_clk);
        flag("busy", busy, 1'b1);
        flag("standby", standby, 1'b0);
        waitIdle();
        note(8'h10, 8'hff);
        go({OP_RDSR, 56'h0}, 1, 1);
        $display("test erase done");
        r0 = 8'($random(seed));
        r1 = 8'($random(seed));
        go({OP_WREN, 56'h0}, 1, 0);
        go({OP_PROG, 24'h012010, r0, r1, 16'h0}, 6, 0);
        waitIdle();
        for (int i = 0; i < 4; i++) note(i == 1 ? r0 : i == 2 ? r1 : ERASED, 8'hff);
        go({OP_READ, 24'h01200f, 32'h0}, 4, 4);
        $display("test program done");
        go({OP_WREN, 56'h0}, 1, 0);
        go({OP_WRSR, 8'h3c, 48'h0}, 2, 0);
        note(8'h1c, 8'hff);
        go({OP_RDSR, 56'h0}, 1, 1);
        go({OP_WREN, 56'h0}, 1, 0);
        go({OP_E4K, 24'h012000, 32'h0}, 4, 0);
        waitIdle();
        note(8'h3c, 8'hfd);
        go({OP_RDSR, 56'h0}, 1, 1);
        note(r0, 8'hff);
        go({OP_READ, 24'h012010, 32'h0}, 4, 1);
        wpN <= 1'b0;
        go({OP_WREN, 56'h0}, 1, 0);
        go({OP_WRSR, 56'h0}, 2, 0);
        note(8'h2c, 8'hfd);
        go({OP_RDSR, 56'h0}, 1, 1);
        wpN <= 1'b1;
        go({OP_WREN, 56'h0}, 1, 0);
        go({OP_WRSR, 56'h0}, 2, 0);
        note(8'h30, 8'hff);
        go({OP_RDSR, 56'h0}, 1, 1);
        $display("test protect done");
        note(8'h30, 8'hff);
        note(8'h00, 8'hff);
        note(8'h30, 8'hff);
        go({OP_RDSR, 56'h0}, 1, 2, 1);
        $display("test hold done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
